// *** scs_pkg.sv ***
// scs_pkg: constants and types of the setpoint and control-signal block
package scs_pkg;
	// ---------------------------------------------------------------
	// apb register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RAMP = 8'h04;
	localparam logic [7:0] REG_LIMIT = 8'h08;
	localparam logic [7:0] REG_WINT = 8'h0C;
	localparam logic [7:0] REG_WSER = 8'h10;
	localparam logic [7:0] REG_YDDC = 8'h14;
	localparam logic [7:0] REG_SAFE = 8'h18;
	localparam logic [7:0] REG_STAT = 8'h1C;
	// control bits, shared by pins and CTRL[15:0]
	localparam int NDI = 16;
	localparam int B_FRZ_ALL = 0;
	localparam int B_FRZ_STR = 1;
	localparam int B_FRZ_CFG = 2;
	localparam int B_CB = 3;
	localparam int B_MAN = 4;
	localparam int B_TRACK = 5;
	localparam int B_SAFE = 6;
	localparam int B_HOLD = 7;
	localparam int B_EXTSEL = 8;
	localparam int B_PONLY1 = 9;
	localparam int B_PONLY2 = 10;
	localparam int B_PSET = 11;
	localparam int B_BLK_UP = 12;
	localparam int B_BLK_DN = 13;
	localparam int B_RAMP_OFF = 14;
	localparam int B_CB2 = 15;
	// serial bits that belong to controller two
	localparam logic [15:0] SER2_MASK = 16'h0400;
	// configuration bits in CTRL[31:16]
	localparam int C_INNER = 16;
	localparam int C_INNER2 = 17;
	localparam int C_DOUBLE = 18;
	localparam int C_RATIO = 19;
	localparam int C_STEPINT = 20;
	localparam int C_DDC = 21;
	localparam int C_TRKSUP = 22;
	localparam int C_INCSEL = 23;
	localparam int C_SAFEDIR = 24;
	localparam logic [31:0] CTRL_RESET = 32'h0001_0000;
	// key pins
	localparam int NKEY = 6;
	localparam int K_WUP = 0;
	localparam int K_WDN = 1;
	localparam int K_IUP = 2;
	localparam int K_IDN = 3;
	localparam int K_YUP = 4;
	localparam int K_YDN = 5;
	// ---------------------------------------------------------------
	// scaling: one digit is 0.1 %
	// ---------------------------------------------------------------
	localparam logic signed [15:0] W_MIN = 16'hFF9C;
	localparam logic signed [15:0] W_MAX = 16'h044C;
	localparam logic signed [15:0] Y_MIN = 16'h0000;
	localparam logic signed [15:0] Y_MAX = 16'h03E8;
	localparam logic signed [15:0] SP_RESET = 16'h0000;
	localparam logic [16:0] TS_MAX = 17'h18600;
	localparam logic [16:0] TS_OFF = 17'h00000;
	localparam logic [6:0] KSTEP_MIN = 7'h01;
	localparam logic [6:0] KSTEP_MAX = 7'h40;
	localparam logic [1:0] KMOVES_DBL = 2'h3;
	// timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned TS_UNIT_MS = 6000;
	localparam int unsigned FULL_SCALE = 1000;
	localparam int unsigned RAMP_DIV_CYC = CLK_HZ / 1000 * TS_UNIT_MS / FULL_SCALE;
	localparam int unsigned KEY_REPEAT_MS = 200;
	localparam int unsigned KEY_REPEAT_CYC = CLK_HZ / 1000 * KEY_REPEAT_MS;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef logic signed [15:0] scs_sp_t;
	typedef enum logic [1:0] {
		LVL_PROC = 2'b00,
		LVL_PARAM = 2'b01,
		LVL_STRUCT = 2'b10
	} scs_lvl_t;
	typedef struct packed {
		logic [1:0] lvl;
		logic [NKEY-1:0] key;
		logic [NDI-1:0] di;
	} scs_pin_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} scs_apb_req_t;
	typedef struct packed {
		scs_pin_t sync1;
		scs_pin_t sync2;
		logic [31:0] ctrl;
		logic [16:0] ts;
		scs_sp_t lo;
		scs_sp_t hi;
		scs_sp_t wi;
		scs_sp_t wes;
		scs_sp_t winc;
		scs_sp_t weff;
		scs_sp_t ydd;
		scs_sp_t ysafe;
		scs_sp_t yman;
		scs_sp_t y;
		logic [16:0] pre;
		logic [16:0] tcnt;
		logic [21:0] kcnt;
		logic [6:0] kstep;
		logic [1:0] kmoves;
		logic kheld;
		logic [31:0] prdata;
		logic pslverr;
	} scs_state_t;
endpackage : scs_pkg

// *** scs_setpoint_ctrl.sv ***
// scs_setpoint_ctrl: control signals, setpoint path and output mode select
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - freeze_all blocks all operation and configuration; only display remains.
// - freeze_structuring allows parameter level only, refuses structuring.
// - freeze_config blocks parameterization and structuring; process operation only.
// - manual_external_request holds output; front keys adjust manipulated variable.
// - tracking drives output to track_target unless internal position simulation.
// - safe mode gives safety value, or 0/100 % with internal simulation.
// - ramp_hold stops a ramped setpoint change in progress.
// - ext_source_sel picks analog input versus serial or incremental path.
// - p_only_ctrl_one and p_only_ctrl_two select proportional-only operation.
// - single controllers switch to parameter set two; double ones ignore it.
// - serial controller-two bits act only with computer_ready_two high and inner_key_two low.
// - internal setpoint is key adjustable while the internal indicator is lit.
// - keys step 1 digit first, then accelerate; release restarts smallest step.
// - serial link presets internal setpoint absolutely whenever keys may adjust.
// - external setpoint from analog, incremental or serial path per selection.
// - ramp_time_param sets full-scale travel time, zero means no limit.
// - ramp_time_param also sets incremental adjustment travel rate.
// - untracked source switches ramp; tracking_suppress_switch disables follow-up.
// - ramp-disable signal bypasses the setpoint ramp.
// - effective setpoint clamped to bounds except in ratio controllers.
// - computer operation is not inner key and computer_ready.
module scs_setpoint_ctrl
	import scs_pkg::*;
#(
	parameter int unsigned RAMP_DIV = RAMP_DIV_CYC,
	parameter int unsigned KEY_REPEAT = KEY_REPEAT_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire scs_apb_req_t apb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire scs_pin_t pins_i,
	input wire scs_sp_t w_analog_i,
	input wire scs_sp_t y_auto_i,
	input wire scs_sp_t track_target_i,
	output scs_sp_t w_eff_o,
	output scs_sp_t y_o,
	output logic computer_op_o,
	output logic internal_lit_o,
	output logic allow_op_o,
	output logic allow_param_o,
	output logic allow_struct_o,
	output scs_lvl_t level_o,
	output logic [1:0] p_only_o,
	output logic param_set_two_o
);
	// ---------------------------------------------------------------
	// state and working signals
	// ---------------------------------------------------------------
	scs_state_t s;
	scs_state_t next_s;
	logic [NDI-1:0] sig;
	logic gate2;
	logic computer_op;
	logic fa;
	logic fc;
	logic fs;
	logic key_ok;
	logic ramp_on;
	logic pre_tick;
	logic rtick;
	logic kany;
	logic kmove;
	logic setup;
	logic access;
	logic wr_ok;
	scs_sp_t ext;
	scs_sp_t target;
	scs_sp_t ycand;
	scs_sp_t wd_lo;
	scs_sp_t wd_hi;
	logic signed [16:0] kd;

	// saturate a widened value into [lo, hi]
	function automatic scs_sp_t sat(input logic signed [16:0] v, input scs_sp_t lo,
		input scs_sp_t hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return scs_sp_t'(v[15:0]);
	endfunction : sat

	// move one digit toward a goal
	function automatic scs_sp_t toward(input scs_sp_t cur, input scs_sp_t goal);
		if (cur < goal) begin
			return cur + 16'sh0001;
		end else if (cur > goal) begin
			return cur - 16'sh0001;
		end
		return cur;
	endfunction : toward

	// ---------------------------------------------------------------
	// control signal decode
	// ---------------------------------------------------------------
	// pins OR serial presets; controller-two serial bits gated
	always_comb begin
		gate2 = (s.sync2.di[B_CB2] | s.ctrl[B_CB2]) & ~s.ctrl[C_INNER2];
		sig = s.sync2.di | (s.ctrl[15:0] & (gate2 ? 16'hFFFF : ~SER2_MASK));
		computer_op = ~s.ctrl[C_INNER] & sig[B_CB];
		fa = sig[B_FRZ_ALL];
		fc = sig[B_FRZ_CFG];
		fs = sig[B_FRZ_STR];
		key_ok = ~computer_op & ~fa;
		ramp_on = (s.ts != TS_OFF) & ~sig[B_RAMP_OFF];
	end

	// operating levels granted from the front panel request
	always_comb begin
		allow_op_o = ~fa;
		allow_param_o = ~fa & ~fc;
		allow_struct_o = ~fa & ~fc & ~fs;
		level_o = LVL_PROC;
		if (s.sync2.lvl == LVL_STRUCT && allow_struct_o) begin
			level_o = LVL_STRUCT;
		end else if (s.sync2.lvl != LVL_PROC && allow_param_o) begin
			level_o = LVL_PARAM;
		end
	end

	// ---------------------------------------------------------------
	// ramp timebase: one digit per ts * RAMP_DIV cycles
	// ---------------------------------------------------------------
	// two stages keep 9984 min inside 34 bits of counters
	always_comb begin
		pre_tick = (s.pre == 17'(RAMP_DIV - 1));
		if (s.ts == TS_OFF) begin
			rtick = pre_tick;
		end else begin
			rtick = pre_tick && (s.tcnt == s.ts - 17'h00001);
		end
	end

	// ---------------------------------------------------------------
	// setpoint source and limits
	// ---------------------------------------------------------------
	always_comb begin
		if (sig[B_EXTSEL]) begin
			ext = w_analog_i;
		end else if (s.ctrl[C_INCSEL]) begin
			ext = s.winc;
		end else begin
			ext = s.wes;
		end
		target = computer_op ? ext : s.wi;
		if (!s.ctrl[C_RATIO]) begin
			target = sat(17'(target), s.lo, s.hi);
		end
	end

	// ---------------------------------------------------------------
	// output mode selection
	// ---------------------------------------------------------------
	// priority: safety, tracking, manual, ddc, automatic
	always_comb begin
		if (sig[B_SAFE]) begin
			if (s.ctrl[C_STEPINT]) begin
				ycand = s.ctrl[C_SAFEDIR] ? Y_MAX : Y_MIN;
			end else begin
				ycand = s.ysafe;
			end
		end else if (sig[B_TRACK] && !s.ctrl[C_STEPINT]) begin
			ycand = track_target_i;
		end else if (sig[B_MAN]) begin
			ycand = s.yman;
		end else if (s.ctrl[C_DDC] && computer_op) begin
			ycand = s.ydd;
		end else begin
			ycand = y_auto_i;
		end
		// limit switches hold the output against the blocked direction
		if (sig[B_BLK_UP] && ycand > s.y) begin
			ycand = s.y;
		end
		if (sig[B_BLK_DN] && ycand < s.y) begin
			ycand = s.y;
		end
	end

	// ---------------------------------------------------------------
	// key progression and apb decode helpers
	// ---------------------------------------------------------------
	always_comb begin
		kany = s.sync2.key[K_WUP] | s.sync2.key[K_WDN] | s.sync2.key[K_YUP]
			| s.sync2.key[K_YDN];
		kmove = kany & (~s.kheld | (s.kcnt == 22'(KEY_REPEAT - 1)));
		kd = $signed({10'h000, s.kstep});
		setup = apb_i.psel & ~apb_i.penable;
		access = apb_i.psel & apb_i.penable;
		wd_lo = scs_sp_t'(apb_i.pwdata[15:0]);
		wd_hi = scs_sp_t'(apb_i.pwdata[31:16]);
	end

	// write admission, evaluated in the setup cycle
	always_comb begin
		wr_ok = 1'b0;
		if (apb_i.paddr == REG_CTRL) begin
			wr_ok = 1'b1;
		end else if (apb_i.paddr == REG_RAMP) begin
			wr_ok = allow_param_o && apb_i.pwdata[16:0] <= TS_MAX;
		end else if (apb_i.paddr == REG_LIMIT) begin
			wr_ok = allow_param_o && wd_lo >= W_MIN && wd_hi <= W_MAX && wd_lo <= wd_hi;
		end else if (apb_i.paddr == REG_SAFE) begin
			wr_ok = allow_param_o && wd_lo >= Y_MIN && wd_lo <= Y_MAX;
		end else if (apb_i.paddr == REG_WINT) begin
			wr_ok = key_ok && wd_lo >= W_MIN && wd_lo <= W_MAX;
		end else if (apb_i.paddr == REG_WSER || apb_i.paddr == REG_YDDC) begin
			wr_ok = ~fa;
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.sync1 = pins_i;
		next_s.sync2 = s.sync1;
		// ramp timebase counters
		next_s.pre = pre_tick ? 17'h00000 : s.pre + 17'h00001;
		if (pre_tick) begin
			next_s.tcnt = (rtick || s.ts == TS_OFF) ? 17'h00000 : s.tcnt + 17'h00001;
		end
		// key repeat timer and step progression
		next_s.kheld = kany;
		if (!kany) begin
			next_s.kcnt = '0;
			next_s.kstep = KSTEP_MIN;
			next_s.kmoves = 2'h0;
		end else begin
			next_s.kcnt = kmove ? 22'h000000 : s.kcnt + 22'h000001;
			if (kmove && s.kheld) begin
				next_s.kmoves = s.kmoves + 2'h1;
				if (s.kmoves == KMOVES_DBL && s.kstep != KSTEP_MAX) begin
					next_s.kstep = {s.kstep[5:0], 1'b0};
				end
			end
		end
		// effective setpoint: jump when unlimited, else crawl one digit
		if (!ramp_on) begin
			next_s.weff = target;
		end else if (rtick && !sig[B_HOLD]) begin
			next_s.weff = toward(s.weff, target);
		end
		// follow-up of the inactive sources keeps switching bumpless
		if (!s.ctrl[C_TRKSUP]) begin
			if (computer_op) begin
				next_s.wi = s.weff;
			end
			if (!computer_op || sig[B_EXTSEL] || !s.ctrl[C_INCSEL]) begin
				next_s.winc = s.weff;
			end
			if (!computer_op || sig[B_EXTSEL] || s.ctrl[C_INCSEL]) begin
				next_s.wes = s.weff;
			end
		end
		// incremental external setpoint moves at the ramp rate
		if (!fa && rtick && computer_op && !sig[B_EXTSEL] && s.ctrl[C_INCSEL]) begin
			if (s.sync2.key[K_IUP] && !s.sync2.key[K_IDN]) begin
				next_s.winc = sat(17'(s.winc) + 17'sh00001, W_MIN, W_MAX);
			end else if (s.sync2.key[K_IDN] && !s.sync2.key[K_IUP]) begin
				next_s.winc = sat(17'(s.winc) - 17'sh00001, W_MIN, W_MAX);
			end
		end
		// front keys on the internal setpoint
		if (kmove && key_ok) begin
			if (s.sync2.key[K_WUP]) begin
				next_s.wi = sat(17'(s.wi) + kd, W_MIN, W_MAX);
			end else if (s.sync2.key[K_WDN]) begin
				next_s.wi = sat(17'(s.wi) - kd, W_MIN, W_MAX);
			end
		end
		// manual output: keys adjust, otherwise follow for bumpless entry
		if (sig[B_MAN] && !fa) begin
			if (kmove && s.sync2.key[K_YUP]) begin
				next_s.yman = sat(17'(s.yman) + kd, Y_MIN, Y_MAX);
			end else if (kmove && s.sync2.key[K_YDN]) begin
				next_s.yman = sat(17'(s.yman) - kd, Y_MIN, Y_MAX);
			end
		end else if (!sig[B_MAN]) begin
			next_s.yman = s.y;
		end
		next_s.y = ycand;
		// apb: answer prepared in setup, write lands in access
		if (setup) begin
			next_s.pslverr = apb_i.pwrite ? ~wr_ok : 1'b0;
			next_s.prdata = 32'h0000_0000;
			if (apb_i.paddr == REG_CTRL) begin
				next_s.prdata = s.ctrl;
			end else if (apb_i.paddr == REG_RAMP) begin
				next_s.prdata = {15'h0000, s.ts};
			end else if (apb_i.paddr == REG_LIMIT) begin
				next_s.prdata = {s.hi, s.lo};
			end else if (apb_i.paddr == REG_WINT) begin
				next_s.prdata = {16'h0000, s.wi};
			end else if (apb_i.paddr == REG_WSER) begin
				next_s.prdata = {16'h0000, s.wes};
			end else if (apb_i.paddr == REG_YDDC) begin
				next_s.prdata = {16'h0000, s.ydd};
			end else if (apb_i.paddr == REG_SAFE) begin
				next_s.prdata = {16'h0000, s.ysafe};
			end else if (apb_i.paddr == REG_STAT) begin
				next_s.prdata = {8'h00, (s.weff != target), param_set_two_o, p_only_o,
					allow_struct_o, allow_param_o, allow_op_o, computer_op, s.weff};
				next_s.pslverr = apb_i.pwrite;
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		if (access && apb_i.pwrite && !s.pslverr) begin
			if (apb_i.paddr == REG_CTRL) begin
				next_s.ctrl = apb_i.pwdata;
			end else if (apb_i.paddr == REG_RAMP) begin
				next_s.ts = apb_i.pwdata[16:0];
				next_s.tcnt = 17'h00000;
			end else if (apb_i.paddr == REG_LIMIT) begin
				next_s.lo = wd_lo;
				next_s.hi = wd_hi;
			end else if (apb_i.paddr == REG_WINT) begin
				next_s.wi = wd_lo;
			end else if (apb_i.paddr == REG_WSER) begin
				next_s.wes = wd_lo;
			end else if (apb_i.paddr == REG_YDDC) begin
				next_s.ydd = wd_lo;
			end else if (apb_i.paddr == REG_SAFE) begin
				next_s.ysafe = wd_lo;
			end
		end
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.lo <= W_MIN;
			s.hi <= W_MAX;
			s.kstep <= KSTEP_MIN;
		end else begin
			s <= next_s;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign prdata_o = s.prdata;
	assign pready_o = 1'b1;
	assign pslverr_o = s.pslverr & access;
	assign w_eff_o = s.weff;
	assign y_o = s.y;
	assign computer_op_o = computer_op;
	assign internal_lit_o = ~computer_op;
	assign p_only_o = {sig[B_PONLY2], sig[B_PONLY1]};
	assign param_set_two_o = ~s.ctrl[C_DOUBLE] & sig[B_PSET];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb_a @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	AST_FREEZE_ALL: assert property (fa |-> !allow_op_o && !allow_param_o
		&& level_o == LVL_PROC) else $error("freeze_all leaves operation open");
	AST_FREEZE_STR: assert property (fs && !fa && !fc && s.sync2.lvl == LVL_STRUCT
		|-> level_o == LVL_PARAM) else $error("structuring not refused");
	AST_FREEZE_CFG: assert property (fc |-> level_o == LVL_PROC
		&& !allow_struct_o) else $error("freeze_config leaves levels open");
	AST_COMP_OP: assert property (computer_op_o == (!s.ctrl[C_INNER] && sig[B_CB]))
		else $error("computer operation term wrong");
	AST_TRACK: assert property (sig[B_TRACK] && !sig[B_SAFE] && !s.ctrl[C_STEPINT]
		&& !sig[B_BLK_UP] && !sig[B_BLK_DN] |=> y_o == $past(track_target_i))
		else $error("output does not follow track target");
	AST_SAFE_STEP: assert property (sig[B_SAFE] && s.ctrl[C_STEPINT] && s.ctrl[C_SAFEDIR]
		&& !sig[B_BLK_UP] |=> y_o == Y_MAX) else $error("safety drive not at 100 %");
	AST_HOLD: assert property (sig[B_HOLD] && ramp_on |=> $stable(w_eff_o))
		else $error("ramp moved under hold");
	AST_BLOCK_UP: assert property (sig[B_BLK_UP] |=> y_o <= $past(y_o))
		else $error("output rose while blocked");
	AST_KEY_RESET: assert property (!kany ##1 kany |-> s.kstep == KSTEP_MIN)
		else $error("key step not restarted");
	AST_NO_LIMIT: assert property (!ramp_on && !s.ctrl[C_RATIO] |=>
		w_eff_o >= $past(s.lo) && w_eff_o <= $past(s.hi)) else $error("setpoint outside bounds");
	AST_PONLY2: assert property (!gate2 |-> p_only_o[1] == s.sync2.di[B_PONLY2])
		else $error("controller two serial bit acted");

	COV_RAMP: cover property (ramp_on && rtick && w_eff_o != target);
	COV_KEY_ACCEL: cover property (kmove && s.kstep == KSTEP_MAX);
	COV_SAFE: cover property (sig[B_SAFE] && !s.ctrl[C_STEPINT]);
	COV_APB_ERR: cover property (pslverr_o);
endmodule : scs_setpoint_ctrl

`default_nettype wire

// *** scs_host_model.sv ***
// scs_host_model: supervisory computer issuing apb transfers to the setpoint block
`timescale 1ns/10ps
`default_nettype none
module scs_host_model
	import scs_pkg::*;
(
	input wire logic mclk_i,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	output scs_apb_req_t apb_o
);
	// ---------------------------------------------------------------
	// apb master
	// ---------------------------------------------------------------
	initial begin
		apb_o = '0;
	end
	// a released bus shows the inverse of the last request, so stale values never match
	// only absolute values reach the setpoint registers, never increments
	// no local limit on the wait: a stuck slave is caught by the bench watchdog
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		apb_o <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge mclk_i);
		apb_o.penable <= 1'b1;
		do begin
			@(posedge mclk_i);
		end while (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		apb_o <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
		@(posedge mclk_i);
	endtask : xfer
endmodule : scs_host_model
`default_nettype wire

// *** scs_setpoint_ctrl_tb.sv ***
// scs_setpoint_ctrl_tb: self-checking bench of the setpoint and control-signal block
`timescale 1ns/10ps
`default_nettype none
module scs_setpoint_ctrl_tb;
	import scs_pkg::*;
	logic mclk_i, rst_i, pready_o, pslverr_o, computer_op_o, internal_lit_o;
	logic allow_op_o, allow_param_o, allow_struct_o, param_set_two_o;
	logic [31:0] prdata_o, seed;
	logic [1:0] p_only_o;
	scs_apb_req_t apb;
	scs_pin_t pins;
	scs_sp_t w_analog_i, y_auto_i, track_target_i, w_eff_o, y_o, v, s;
	scs_lvl_t level_o;
	int num_errors = 0;
	int checks_done = 0;
	// ---------------------------------------------------------------
	// design, host model, clock
	// ---------------------------------------------------------------
	scs_setpoint_ctrl #(.RAMP_DIV(4), .KEY_REPEAT(8)) scs_setpoint_ctrl_i (.mclk_i(mclk_i),
		.rst_i(rst_i), .apb_i(apb), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .pins_i(pins), .w_analog_i(w_analog_i), .y_auto_i(y_auto_i),
		.track_target_i(track_target_i), .w_eff_o(w_eff_o), .y_o(y_o),
		.computer_op_o(computer_op_o), .internal_lit_o(internal_lit_o),
		.allow_op_o(allow_op_o), .allow_param_o(allow_param_o),
		.allow_struct_o(allow_struct_o), .level_o(level_o), .p_only_o(p_only_o),
		.param_set_two_o(param_set_two_o));
	scs_host_model scs_host_model_i (.mclk_i(mclk_i), .prdata_i(prdata_o),
		.pready_i(pready_o), .pslverr_i(pslverr_o), .apb_o(apb));
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		logic [31:0] r;
		logic x;
		scs_host_model_i.xfer(1'b1, a, d, r, x);
		chk("pslverr", 32'(x), 32'(e));
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic x;
		scs_host_model_i.xfer(1'b0, a, 32'h0, r, x);
		chk("prdata", r, exp);
	endtask : rd
	function automatic scs_sp_t clampf(scs_sp_t x, scs_sp_t lo, scs_sp_t hi);
		return (x < lo) ? lo : (x > hi) ? hi : x;
	endfunction : clampf
	// 32-bit lfsr, taps 32 22 2 1
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : cyc
	task print_verdict();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	// watchdog, far above the length of the sequence
	initial begin
		cyc(5000);
		num_errors++;
		print_verdict();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		pins = '0;
		pins.lvl = LVL_STRUCT;
		w_analog_i = '0;
		y_auto_i = '0;
		track_target_i = '0;
		seed = 32'd78008;
		cyc(3);
		rst_i <= 1'b0;
		cyc(1);
		rd(REG_CTRL, CTRL_RESET);
		rd(REG_LIMIT, {W_MAX, W_MIN});
		wr(8'h20, 32'h0, 1'b1);
		wr(REG_STAT, 32'h0, 1'b1);
		$display("reset and map done");
		wr(REG_CTRL, CTRL_RESET | 32'h1, 1'b0);
		wr(REG_RAMP, 32'h5, 1'b1);
		wr(REG_WINT, 32'h5, 1'b1);
		chk("allow_op", 32'(allow_op_o), 32'h0);
		chk("level", 32'(level_o), 32'(LVL_PROC));
		wr(REG_CTRL, CTRL_RESET | 32'h2, 1'b0);
		chk("allow_struct", 32'(allow_struct_o), 32'h0);
		chk("allow_param", 32'(allow_param_o), 32'h1);
		chk("level", 32'(level_o), 32'(LVL_PARAM));
		wr(REG_CTRL, CTRL_RESET | 32'h4, 1'b0);
		wr(REG_LIMIT, 32'h0, 1'b1);
		chk("allow_param", 32'(allow_param_o), 32'h0);
		chk("allow_op", 32'(allow_op_o), 32'h1);
		chk("level", 32'(level_o), 32'(LVL_PROC));
		wr(REG_CTRL, CTRL_RESET, 1'b0);
		chk("level", 32'(level_o), 32'(LVL_STRUCT));
		wr(REG_RAMP, 32'd99841, 1'b1);
		wr(REG_RAMP, 32'd99840, 1'b0);
		wr(REG_RAMP, 32'h0, 1'b0);
		$display("freeze done");
		// internal setpoint preset from the link, clamped to the limits
		wr(REG_LIMIT, 32'h01F4_0000, 1'b0);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			v = scs_sp_t'(seed % 1201) - 16'sh0064;
			wr(REG_WINT, 32'(v), 1'b0);
			cyc(1);
			chk("w_eff", 32'(w_eff_o), 32'(clampf(v, 16'sh0000, 16'sh01F4)));
		end
		wr(REG_CTRL, CTRL_RESET | 32'h0008_0000, 1'b0);
		cyc(1);
		chk("w_ratio", 32'(w_eff_o), 32'(v));
		$display("setpoint done");
		// computer operation truth table
		for (int i = 0; i < 4; i++) begin
			wr(REG_CTRL, {15'h0, i[0], 12'h0, i[1], 3'h0}, 1'b0);
			chk("computer_op", 32'(computer_op_o), 32'(i[1] & ~i[0]));
			chk("lit", 32'(internal_lit_o), 32'(i[1] & ~i[0]) ^ 32'h1);
		end
		// back to computer operation: key path closed, serial source active
		wr(REG_CTRL, 32'h0000_0008, 1'b0);
		wr(REG_WINT, 32'h5, 1'b1);
		wr(REG_WSER, 32'd300, 1'b0);
		cyc(2);
		chk("w_ser", 32'(w_eff_o), 32'd300);
		seed = lfsr(seed);
		w_analog_i <= scs_sp_t'(seed % 1201) - 16'sh0064;
		pins.di[B_EXTSEL] <= 1'b1;
		cyc(4);
		chk("w_ana", 32'(w_eff_o), 32'(clampf(w_analog_i, 16'sh0000, 16'sh01F4)));
		pins.di[B_EXTSEL] <= 1'b0;
		$display("computer done");
		// ramp, hold and bypass
		wr(REG_CTRL, CTRL_RESET, 1'b0);
		wr(REG_WINT, 32'h0, 1'b0);
		wr(REG_RAMP, 32'h1, 1'b0);
		wr(REG_WINT, 32'd100, 1'b0);
		cyc(40);
		chk("ramp", 32'(w_eff_o > 0 && w_eff_o < 20), 32'h1);
		pins.di[B_HOLD] <= 1'b1;
		cyc(3);
		s = w_eff_o;
		cyc(20);
		chk("hold", 32'(w_eff_o), 32'(s));
		pins.di[B_HOLD] <= 1'b0;
		pins.di[B_RAMP_OFF] <= 1'b1;
		cyc(4);
		chk("bypass", 32'(w_eff_o), 32'd100);
		pins.di[B_RAMP_OFF] <= 1'b0;
		wr(REG_RAMP, 32'h0, 1'b0);
		// keys: one digit first, then the repeat
		pins.key[K_WUP] <= 1'b1;
		cyc(6);
		chk("key1", 32'(w_eff_o), 32'd101);
		cyc(8);
		chk("key2", 32'(w_eff_o), 32'd102);
		pins.key[K_WUP] <= 1'b0;
		$display("ramp and keys done");
		// output modes in priority order
		y_auto_i <= 16'sd200;
		wr(REG_SAFE, 32'd350, 1'b0);
		pins.di[B_SAFE] <= 1'b1;
		pins.di[B_TRACK] <= 1'b1;
		track_target_i <= 16'sd600;
		cyc(4);
		chk("y_safe", 32'(y_o), 32'd350);
		pins.di[B_SAFE] <= 1'b0;
		cyc(4);
		chk("y_track", 32'(y_o), 32'd600);
		pins.di[B_TRACK] <= 1'b0;
		pins.di[B_BLK_UP] <= 1'b1;
		cyc(4);
		chk("y_auto", 32'(y_o), 32'd200);
		y_auto_i <= 16'sd700;
		cyc(3);
		chk("y_blk", 32'(y_o), 32'd200);
		y_auto_i <= 16'sd100;
		cyc(3);
		chk("y_dn", 32'(y_o), 32'd100);
		pins.di[B_BLK_UP] <= 1'b0;
		// p-only and parameter sets
		pins.di[B_PONLY1] <= 1'b1;
		pins.di[B_PSET] <= 1'b1;
		wr(REG_CTRL, CTRL_RESET | 32'h8400, 1'b0);
		chk("p_only", 32'(p_only_o), 32'h3);
		chk("pset2", 32'(param_set_two_o), 32'h1);
		wr(REG_CTRL, CTRL_RESET | 32'h0006_8400, 1'b0);
		chk("p_only", 32'(p_only_o), 32'h1);
		chk("pset2", 32'(param_set_two_o), 32'h0);
		// manual entry is bumpless, then one y key step
		pins.di[B_MAN] <= 1'b1;
		cyc(3);
		pins.key[K_YUP] <= 1'b1;
		cyc(5);
		chk("y_man", 32'(y_o), 32'd101);
		pins.key[K_YUP] <= 1'b0;
		pins.di[B_MAN] <= 1'b0;
		// ddc output under computer operation, then blocked downwards
		wr(REG_CTRL, 32'h0020_0008, 1'b0);
		pins.di[B_BLK_DN] <= 1'b1;
		wr(REG_YDDC, 32'd450, 1'b0);
		cyc(1);
		chk("y_ddc", 32'(y_o), 32'd450);
		wr(REG_YDDC, 32'd50, 1'b0);
		cyc(1);
		chk("y_blk_dn", 32'(y_o), 32'd450);
		// internal position simulation: safety drives to full travel
		pins.di[B_BLK_DN] <= 1'b0;
		pins.di[B_SAFE] <= 1'b1;
		wr(REG_CTRL, 32'h0110_0000, 1'b0);
		cyc(1);
		chk("y_safe_step", 32'(y_o), 32'(Y_MAX));
		pins.di[B_SAFE] <= 1'b0;
		$display("output and modes done");
		print_verdict();
	end
endmodule : scs_setpoint_ctrl_tb
`default_nettype wire
